// ### rtl/irq_route_pkg.sv
package irq_route_pkg;
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h6e0;
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h6e4;
    localparam logic [11:0] OFS_ROUTE_SELECT = 12'h6ec;
    localparam logic [11:0] OFS_SOFT_TRIGGER_B = 12'h6f0;
    localparam logic [11:0] OFS_MAILBOX_0 = 12'h700;
    localparam logic [11:0] OFS_MAILBOX_1 = 12'h704;
    localparam logic [11:0] OFS_MAILBOX_2 = 12'h708;
    localparam logic [11:0] OFS_MAILBOX_3 = 12'h70c;
    localparam int ADDR_W = 12;
    localparam int NUM_MBOX = 4;

    // Source bit positions, shared by status, enable and route select
    localparam int BIT_SYSERR = 21;
    localparam int BIT_LOCAL_IRQ_IN = 20;
    localparam int BIT_MAILBOX_WORD_0 = 16;
    localparam int BIT_PARITY_ERR = 15;
    localparam int BIT_POWER_CHANGE = 14;
    localparam int BIT_OUT_POST_NONEMPTY = 13;
    localparam int BIT_IN_POST_NEW = 12;
    localparam int BIT_IN_FREE_EMPTY = 11;
    localparam int BIT_OUT_FREE_EMPTY = 10;
    localparam int BIT_IN_POST_FULL = 9;
    localparam int BIT_OUT_FREE_FULL = 8;
    localparam int BIT_SOFT0 = 0;
    localparam int BIT_SOFT2 = 2;
    localparam int BIT_SOFT3 = 3;

    // Route select: writable bits, fixed values of read-only bits
    localparam logic [31:0] ROUTE_WRITABLE = 32'h000f_8f0f;
    localparam logic [31:0] ROUTE_FIXED = 32'h0010_2000;
    localparam logic [31:0] ROUTE_RESET = 32'h0010_2000;
    // Sources this block implements
    localparam logic [31:0] SRC_MASK = 32'h003f_ff0f;
    // Soft trigger b bits accepted
    localparam logic [31:0] TRIG_B_MASK = 32'h0000_000c;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ### rtl/irq_src_if.sv
interface irq_src_if;
    logic [31:0] pending;
    logic [31:0] enable;
    logic [31:0] route;
    logic local_bus_irq;
    logic pci_irq;
    modport ctrl (output pending, output enable, output route, input local_bus_irq, input pci_irq);
    modport steer (input pending, input enable, input route, output local_bus_irq, output pci_irq);
endinterface

// ### rtl/irq_steer.sv
module irq_steer
(
    input wire logic clk,
    input wire logic rst,
    irq_src_if.steer src
);
    typedef struct packed
    {
        logic local_bus_irq;
        logic pci_irq;
    } state_s;
    state_s q;
    state_s next_q;

    always_comb
    begin
        next_q = q;
        next_q.local_bus_irq = |(src.pending & src.enable & ~src.route);
        next_q.pci_irq = |(src.pending & src.enable & src.route);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= next_q;
    end

    assign src.local_bus_irq = q.local_bus_irq;
    assign src.pci_irq = q.pci_irq;
endmodule

// ### rtl/interrupt_routing_mailboxes.sv
// Decided for this implementation: the strobed register port.
module interrupt_routing_mailboxes
    import irq_route_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic [31:0] hw_events,
    output logic local_bus_irq,
    output logic pci_irq,
    output logic irq
);
    typedef struct packed
    {
        logic [31:0] status;
        logic [31:0] enable;
        logic [31:0] route;
        logic [NUM_MBOX-1:0][31:0] mailbox;
        logic [31:0] rdata;
    } state_s;

    state_s q;
    state_s next_q;
    irq_src_if src ();

    function automatic logic [31:0] route_merge(input logic [31:0] old_val, input logic [31:0] wr_val);
        route_merge = (old_val & ~ROUTE_WRITABLE) | (wr_val & ROUTE_WRITABLE);
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    always_comb
    begin
        logic [31:0] set_bits;
        logic [31:0] clr_bits;
        set_bits = hw_events & SRC_MASK;
        clr_bits = ZERO_WORD;
        next_q = q;
        next_q.rdata = ZERO_WORD;
        if (wr_stb)
        begin
            if (hit(addr, OFS_IRQ_STATUS))
                clr_bits = wdata & SRC_MASK;
            if (hit(addr, OFS_IRQ_ENABLE))
            begin
                next_q.enable = wdata & SRC_MASK & ~32'h0000_0003;
                set_bits[BIT_SOFT0 +: 2] = set_bits[BIT_SOFT0 +: 2] | wdata[1:0];
            end
            if (hit(addr, OFS_ROUTE_SELECT))
                next_q.route = route_merge(q.route, wdata);
            if (hit(addr, OFS_SOFT_TRIGGER_B))
                set_bits = set_bits | (wdata & TRIG_B_MASK);
            for (int i = 0; i < NUM_MBOX; i++)
            begin
                if (hit(addr, OFS_MAILBOX_0 + ADDR_W'(4 * i)))
                begin
                    next_q.mailbox[i] = wdata;
                    set_bits[BIT_MAILBOX_WORD_0 + i] = 1'b1;
                end
            end
        end
        // Set wins over a same-cycle clear
        next_q.status = (q.status & ~clr_bits) | set_bits;
        // Read-only route bits held at fixed values
        next_q.route = (next_q.route & ROUTE_WRITABLE) | ROUTE_FIXED;
        if (rd_stb)
        begin
            unique case (addr)
                OFS_IRQ_STATUS: next_q.rdata = q.status;
                OFS_IRQ_ENABLE: next_q.rdata = q.enable;
                OFS_ROUTE_SELECT: next_q.rdata = q.route;
                OFS_SOFT_TRIGGER_B: next_q.rdata = ZERO_WORD;
                OFS_MAILBOX_0: next_q.rdata = q.mailbox[0];
                OFS_MAILBOX_1: next_q.rdata = q.mailbox[1];
                OFS_MAILBOX_2: next_q.rdata = q.mailbox[2];
                OFS_MAILBOX_3: next_q.rdata = q.mailbox[3];
                default: next_q.rdata = ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            q <= '0;
            q.route <= ROUTE_RESET;
        end
        else
            q <= next_q;
    end

    assign src.pending = q.status;
    assign src.enable = q.enable;
    assign src.route = q.route;

    irq_steer u_steer
    (
        .clk(ref_clk),
        .rst(srst),
        .src(src)
    );

    assign local_bus_irq = src.local_bus_irq;
    assign pci_irq = src.pci_irq;
    assign irq = src.local_bus_irq | src.pci_irq;
    assign rdata = q.rdata;
endmodule

// ### tb/irq_checker.sv
module irq_checker
    import irq_route_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata,
    input wire logic local_bus_irq,
    input wire logic pci_irq,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence rd_at(logic [11:0] a); rd_stb && addr == a; endsequence
    sequence mb1_wr; wr_stb && addr == OFS_MAILBOX_1; endsequence
    sequence mb0_wr; wr_stb && addr == OFS_MAILBOX_0; endsequence
    AST_IRQ_OR: assert property (irq == (local_bus_irq | pci_irq)) else $error("irq or");
    AST_RDATA_IDLE: assert property (!rd_stb |=> rdata == ZERO_WORD) else $error("rdata idle");
    AST_ROUTE_FIXED: assert property (rd_at(OFS_ROUTE_SELECT) |=> (rdata & 32'h0030_7000) == 32'h0010_2000)
        else $error("route fixed");
    AST_TRIG_B_ZERO: assert property (rd_at(OFS_SOFT_TRIGGER_B) |=> rdata == ZERO_WORD) else $error("trig b");
    AST_EN_TRIG_ZERO: assert property (rd_at(OFS_IRQ_ENABLE) |=> rdata[1:0] == 2'h0) else $error("trig a");
    AST_MBOX_BACK: assert property (mb1_wr ##1 rd_at(OFS_MAILBOX_1) |=> rdata == $past(wdata, 2))
        else $error("mailbox");
    AST_MBOX_STATUS: assert property (mb0_wr ##1 rd_at(OFS_IRQ_STATUS) |=> rdata[BIT_MAILBOX_WORD_0]) else $error("mbox st");
    AST_QUIET_START: assert property ($fell(srst) |-> !local_bus_irq && !pci_irq) else $error("start");
endmodule
bind interrupt_routing_mailboxes irq_checker chk (.*);

// ### tb/event_source.sv
module event_source
(
    input wire logic ref_clk,
    input wire logic [31:0] fire,
    output logic [31:0] hw_events = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // One-cycle event pulses toward the block
    always @(posedge ref_clk)
        hw_events <= fire;
endmodule

// ### tb/tb_interrupt_routing_mailboxes.sv
module tb_interrupt_routing_mailboxes
    import irq_route_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, srst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, local_bus_irq, pci_irq, irq;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, fire = 32'h0, rdata, hw_events;
    int fails = 0, n_compared = 0;
    always #5 ref_clk = ~ref_clk;
    event_source src (.*);
    interrupt_routing_mailboxes dut (.*);
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s exp=%h seen=%h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        @(negedge ref_clk);
        chk("rdata", rdata, e);
        @(posedge ref_clk);
    endtask
    task automatic irqs(logic [1:0] e);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("irq", {29'h0, irq, local_bus_irq, pci_irq}, {29'h0, |e, e});
        @(posedge ref_clk);
    endtask
    task automatic end_of_test;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #20000;
        fails++;
        end_of_test;
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_ROUTE_SELECT, 32'h0010_2000);
        rd(OFS_MAILBOX_2, ZERO_WORD);
        wr(OFS_ROUTE_SELECT, 32'hffff_ffff);
        rd(OFS_ROUTE_SELECT, 32'h001f_af0f);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_MAILBOX_0 + 12'(4 * i), 32'ha5a5_0000 + 32'(i));
            rd(OFS_MAILBOX_0 + 12'(4 * i), 32'ha5a5_0000 + 32'(i));
        end
        wr(OFS_MAILBOX_0, 32'h0000_0001);
        rd(OFS_IRQ_STATUS, 32'h000f_0000);
        irqs(2'b00);
        wr(OFS_IRQ_ENABLE, 32'h0001_0000);
        irqs(2'b01);
        wr(OFS_ROUTE_SELECT, ZERO_WORD);
        irqs(2'b10);
        wr(OFS_IRQ_STATUS, 32'h000f_0000);
        irqs(2'b00);
        wr(OFS_SOFT_TRIGGER_B, 32'h0000_000c);
        rd(OFS_SOFT_TRIGGER_B, ZERO_WORD);
        wr(OFS_IRQ_ENABLE, 32'h0020_0003);
        rd(OFS_IRQ_STATUS, 32'h0000_000f);
        rd(OFS_IRQ_ENABLE, 32'h0020_0000);
        wr(OFS_ROUTE_SELECT, 32'hffff_ffff);
        fire <= 32'h0020_0000;
        @(posedge ref_clk);
        fire <= 32'h0;
        irqs(2'b10);
        wr(OFS_IRQ_STATUS, 32'hffff_ffff);
        wr(OFS_IRQ_ENABLE, 32'h0010_0000);
        fire <= 32'h0010_0000;
        @(posedge ref_clk);
        fire <= 32'h0;
        irqs(2'b01);
        end_of_test;
    end
endmodule
